// File: verilog/uart_dma_sleep_baud_gen.v
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_dma_sleep_defines.vh"

module uart_dma_sleep_baud_gen #(
  parameter FIFO_DEPTH = 64,
  parameter CW         = 7
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // register port
  input  wire [3:0]    addr,
  input  wire [7:0]    wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [7:0]    rdata,
  // channel FIFO state
  input  wire [CW-1:0] tx_count,
  input  wire          tx_shift_empty,
  input  wire          tx_fifo_write,
  input  wire          tx_load,
  input  wire [CW-1:0] rx_count,
  input  wire [CW-1:0] rx_err_count,
  input  wire          rx_timeout_irq,
  input  wire          other_irq,
  // serial line and modem inputs
  input  wire          rx,
  input  wire [3:0]    modem_in,
  input  wire          tx_serial,
  output reg           tx_out,
  // DMA requests
  output reg           tx_dma_request,
  output reg           rx_dma_request,
  // clock control
  output reg           baud16_tick,
  output reg           uart_clk_en,
  output reg           sleeping
);

  // ==========================================================
  // helpers
  // ==========================================================
  function [5:0] word_len;
    input [1:0] sel;
    begin
      word_len = `WLEN_BASE + {4'h0, sel};
    end
  endfunction

  // true when a FIFO fill count is zero
  function is_empty;
    input [CW-1:0] cnt;
    begin
      is_empty = (cnt == {CW{1'b0}});
    end
  endfunction

  // ==========================================================
  // registers
  // ==========================================================
  reg  [7:0]    div_lo_q;
  reg  [7:0]    div_hi_q;
  reg  [7:0]    ien_q;
  reg  [7:0]    fctl_q;
  reg  [7:0]    lctl_q;
  reg  [7:0]    mctl_q;
  reg  [7:0]    efeat_q;
  reg  [CW-1:0] tx_trig_q;
  reg  [CW-1:0] rx_trig_q;
  reg           err_sum_q;

  // receive idle state
  reg           rx_prev_q;
  reg  [3:0]    phase_q;
  reg  [5:0]    high_bits_q;
  reg           rx_idle_q;

  // baud generator state
  reg  [1:0]    presc_q;
  reg  [15:0]   div_cnt_q;
  reg  [3:0]    modem_prev_q;

  wire [15:0]   divisor = {div_hi_q, div_lo_q};
  wire          block_mode;
  wire          sleep_ok;
  wire          can_sleep;
  wire          wake;
  wire          run;
  wire          pre_tick;
  wire          tick;
  wire [5:0]    idle_limit;
  wire [CW:0]   tx_free;
  wire [7:0]    idle_sum;
  wire          tx_empty;
  wire          rx_has_data;
  wire          tx_full;
  wire          rx_at_trig;
  wire [7:0]    lstat_byte;
  wire [7:0]    status_byte;

  // ==========================================================
  // register writes
  // ==========================================================
  // divisor writes while asleep are for the host to avoid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_lo_q  <= `RST_BYTE;
      div_hi_q  <= `RST_BYTE;
      ien_q     <= `RST_BYTE;
      fctl_q    <= `RST_BYTE;
      lctl_q    <= `RST_LCTL;
      mctl_q    <= `RST_BYTE;
      efeat_q   <= `RST_BYTE;
      tx_trig_q <= `RST_TRIG;
      rx_trig_q <= `RST_TRIG;
    end else if (wr) begin
      if (addr == `A_DIV_LO) begin
        div_lo_q <= wdata;
      end else if (addr == `A_DIV_HI) begin
        div_hi_q <= wdata;
      end else if (addr == `A_IEN) begin
        ien_q <= wdata;
      end else if (addr == `A_FCTL) begin
        fctl_q <= wdata;
      end else if (addr == `A_LCTL) begin
        lctl_q <= wdata;
      end else if (addr == `A_MCTL) begin
        mctl_q <= wdata;
      end else if (addr == `A_EFEAT) begin
        efeat_q <= wdata;
      end else if (addr == `A_TX_TRIG) begin
        tx_trig_q <= wdata[CW-1:0];
      end else if (addr == `A_RX_TRIG) begin
        rx_trig_q <= wdata[CW-1:0];
      end
    end
  end

  // ==========================================================
  // status bytes
  // ==========================================================
  assign tx_empty    = is_empty(tx_count);
  assign rx_has_data = !is_empty(rx_count);

  // error summary, transmitter and shift register empty, data held
  assign lstat_byte  = {err_sum_q, tx_empty & tx_shift_empty, tx_empty,
                        4'h0, rx_has_data};
  assign status_byte = {3'h0, rx_idle_q, rx_dma_request,
                        tx_dma_request, baud16_tick, sleeping};

  // ==========================================================
  // register reads
  // ==========================================================
  // read data stands in the cycle after the strobe only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `RST_BYTE;
    end else if (!rd) begin
      rdata <= `RST_BYTE;
    end else if (addr == `A_DIV_LO) begin
      rdata <= div_lo_q;
    end else if (addr == `A_DIV_HI) begin
      rdata <= div_hi_q;
    end else if (addr == `A_IEN) begin
      rdata <= ien_q;
    end else if (addr == `A_FCTL) begin
      rdata <= fctl_q;
    end else if (addr == `A_LCTL) begin
      rdata <= lctl_q;
    end else if (addr == `A_MCTL) begin
      rdata <= mctl_q;
    end else if (addr == `A_LSTAT) begin
      rdata <= lstat_byte;
    end else if (addr == `A_EFEAT) begin
      rdata <= efeat_q;
    end else if (addr == `A_TX_TRIG) begin
      rdata <= {{(8-CW){1'b0}}, tx_trig_q};
    end else if (addr == `A_RX_TRIG) begin
      rdata <= {{(8-CW){1'b0}}, rx_trig_q};
    end else if (addr == `A_STATUS) begin
      rdata <= status_byte;
    end else begin
      rdata <= `RST_BYTE;
    end
  end

  // ==========================================================
  // summary error flag
  // ==========================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      err_sum_q <= 1'b0;
    end else begin
      // follows the error count, so clears only when none are left
      err_sum_q <= !is_empty(rx_err_count);
    end
  end

  // ==========================================================
  // baud generator
  // ==========================================================
  // clocks run only while awake
  assign run = !sleeping;

  // divide-by-4 prescaler ahead of the divisor
  assign pre_tick = run &&
    (!mctl_q[`MC_PRESC] || presc_q == `PRESC_DIV);

  // divisor of N gives one tick per N prescaled cycles, at 16x
  // divisor = clock / prescale / 16 / bit rate
  assign tick = pre_tick && divisor != 16'h0000 &&
    div_cnt_q >= divisor - 16'h0001;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q     <= 2'h0;
      div_cnt_q   <= 16'h0000;
      baud16_tick <= 1'b0;
    end else begin
      // prescaler counts only while selected, so it starts from zero
      if (run) begin
        presc_q <= mctl_q[`MC_PRESC] ? presc_q + 2'h1 : 2'h0;
      end
      // held at zero while unprogrammed: a new divisor starts clean
      if (tick || divisor == 16'h0000) begin
        div_cnt_q <= 16'h0000;
      end else if (pre_tick) begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
      baud16_tick <= tick;
    end
  end

  // ==========================================================
  // receive idle detection
  // ==========================================================
  // line must stay high for four words plus twelve bits
  // with no divisor there are no samples, so the line never becomes idle
  assign idle_sum   = {word_len(lctl_q[1:0]), 2'b00}
                      + {2'b00, `IDLE_EXTRA};
  assign idle_limit = idle_sum[5:0];

  // a start edge realigns the phase so samples fall mid-bit

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_prev_q   <= 1'b1;
      phase_q     <= 4'h0;
      high_bits_q <= 6'h00;
      rx_idle_q   <= 1'b0;
    end else begin
      rx_prev_q <= rx;
      if (rx_prev_q && !rx) begin
        // falling edge realigns the bit phase
        phase_q     <= 4'h0;
        high_bits_q <= 6'h00;
        rx_idle_q   <= 1'b0;
      end else if (tick) begin
        phase_q <= (phase_q == `TICKS_BIT) ? 4'h0
                                           : phase_q + 4'h1;
        if (phase_q == `MID_BIT) begin
          // one sample at the middle of each bit
          if (!rx) begin
            high_bits_q <= 6'h00;
            rx_idle_q   <= 1'b0;
          end else if (high_bits_q + 6'h01 >= idle_limit) begin
            high_bits_q <= idle_limit;
            rx_idle_q   <= 1'b1;
          end else begin
            high_bits_q <= high_bits_q + 6'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // sleep control
  // ==========================================================
  assign sleep_ok = efeat_q[`EF_ENH] & ien_q[`IE_SLEEP];

  assign can_sleep = sleep_ok && rx_idle_q &&
    tx_empty && tx_shift_empty &&
    !other_irq &&
    !rx_has_data;

  assign wake = (rx != rx_prev_q) ||
    (modem_in != modem_prev_q) || tx_fifo_write;

  // last modem pin state, for change detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_prev_q <= 4'h0;
    end else begin
      modem_prev_q <= modem_in;
    end
  end

  // wake beats entry so an event in the entry cycle is never lost
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sleeping     <= 1'b0;
      uart_clk_en  <= 1'b1;
    end else begin
      if (wake || !sleep_ok) begin
        sleeping    <= 1'b0;
        uart_clk_en <= 1'b1;
      end else if (can_sleep) begin
        sleeping    <= 1'b1;
        uart_clk_en <= 1'b0;
      end
    end
  end

  // ==========================================================
  // DMA requests
  // ==========================================================
  assign block_mode = fctl_q[`FC_MODE] &
                      fctl_q[`FC_ENABLE];

  assign tx_free    = FIFO_DEPTH[CW:0] - {1'b0, tx_count};
  assign tx_full    = tx_free == {(CW+1){1'b0}};
  assign rx_at_trig = rx_count >= rx_trig_q;

  // transmit request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_dma_request <= 1'b0;
    end else if (!block_mode) begin
      // single-character transfers
      if (tx_load) begin
        tx_dma_request <= 1'b0;
      end else begin
        tx_dma_request <= tx_empty;
      end
    end else if (tx_full) begin
      tx_dma_request <= 1'b0;
    end else if (tx_free >= {1'b0, tx_trig_q}) begin
      tx_dma_request <= 1'b1;
    end
  end

  // receive request; in block mode clear beats set, so an errored
  // FIFO raises no new request until it is clean
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_dma_request <= 1'b0;
    end else if (!block_mode) begin
      rx_dma_request <= rx_has_data;
    end else if (!rx_has_data || err_sum_q) begin
      rx_dma_request <= 1'b0;
    end else if (rx_at_trig || rx_timeout_irq) begin
      rx_dma_request <= 1'b1;
    end
  end

  // ==========================================================
  // transmit output and break
  // ==========================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_out <= 1'b1;
    end else begin
      // break forces the line low whatever the transmitter sends
      tx_out <= tx_serial & ~lctl_q[`LC_BREAK];
    end
  end

endmodule

`default_nettype wire

// File: verilog/uart_dma_sleep_defines.vh
// Behaviour
// - fifo_control bit three picks request mode
// - mode 0 or FIFOs off: single-character requests
// - single mode: tx request while holding empty
// - single mode: rx request while character held
// - block mode: tx request on trigger space
// - block mode: rx request on trigger/timeout
// - block mode: rx request drops empty/error
// - sleep allowed only with both enable bits
// - sleep needs idle line, empty tx, quiet
// - no sleep while receive FIFO holds data
// - asleep: UART and baud clocks stopped
// - wake on rx, modem change, tx write
// - rx idle after 4x word plus 12
// - receive line sampled mid-bit
// - break bit holds transmit output low
// - baud divisor is 16-bit, 1 upward
// - optional divide-by-4 prescaler, reset divide-by-1
// - baud output runs at 16x bit rate
// - divisor is high latch : low latch
// - zero divisor gives no baud clock
// - one generator times transmit and receive
// - summary error set while errored chars remain
`ifndef UART_DMA_SLEEP_DEFINES_VH
`define UART_DMA_SLEEP_DEFINES_VH

// register map, index on a 4-bit address
`define A_DIV_LO   4'h0
`define A_DIV_HI   4'h1
`define A_IEN      4'h2
`define A_FCTL     4'h3
`define A_LCTL     4'h4
`define A_MCTL     4'h5
`define A_LSTAT    4'h6
`define A_EFEAT    4'h7
`define A_TX_TRIG  4'h8
`define A_RX_TRIG  4'h9
`define A_STATUS   4'hA

// field positions
`define FC_ENABLE  0
`define FC_MODE    3
`define EF_ENH     4
`define IE_SLEEP   4
`define LC_BREAK   6
`define MC_PRESC   7
`define LS_ERRSUM  7

// reset values
`define RST_BYTE   8'h00
`define RST_LCTL   8'h1D
`define RST_TRIG   7'h01

// baud and idle timing
`define PRESC_DIV  2'h3
`define TICKS_BIT  4'hF
`define MID_BIT    4'h7
`define IDLE_EXTRA 6'h0C
`define WLEN_BASE  6'h05

`endif

// File: bench/uart_dma_sleep_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_dma_sleep_defines.vh"
// ==========
// port checks
module uart_dma_sleep_asserts #(parameter CW = 7) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // register writes
  input wire logic [3:0]    addr,
  input wire logic [7:0]    wdata,
  input wire logic          wr,
  // channel inputs
  input wire logic          tx_load,
  input wire logic [CW-1:0] rx_count,
  input wire logic [3:0]    modem_in,
  // outputs
  input wire logic          tx_out,
  input wire logic          tx_dma_request,
  input wire logic          rx_dma_request,
  input wire logic          baud16_tick,
  input wire logic          uart_clk_en,
  input wire logic          sleeping
);
  logic [15:0] div_q;
  logic        pre_q;
  logic        blk_q;
  logic        brk_q;
  logic        c2;
  assign c2 = div_q == 16'h0002 && !pre_q && !sleeping && !wr;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // shadow of the control bits seen on the write port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
      pre_q <= 1'b0;
      blk_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (wr) begin
      if (addr == `A_DIV_LO) div_q[7:0] <= wdata;
      if (addr == `A_DIV_HI) div_q[15:8] <= wdata;
      if (addr == `A_MCTL) pre_q <= wdata[`MC_PRESC];
      if (addr == `A_FCTL) blk_q <= wdata[3] & wdata[0];
      if (addr == `A_LCTL) brk_q <= wdata[`LC_BREAK];
    end
  end
  AST_SLEEP_STOP:
    assert property (sleeping && $past(sleeping) |-> !baud16_tick && !uart_clk_en)
      else $error("clock running while asleep");
  AST_WAKE_MODEM:
    assert property (sleeping && modem_in != $past(modem_in) |-> ##[1:2] !sleeping)
      else $error("no wake on modem change");
  AST_SLEEP_RX:
    assert property ($rose(sleeping) |-> $past(rx_count) == 7'h00)
      else $error("slept with receive data");
  AST_BREAK:
    assert property (brk_q && $past(brk_q) |-> !tx_out)
      else $error("transmit line high in break");
  AST_ZERO_DIV:
    assert property (div_q == 16'h0000 && $past(div_q) == 16'h0000 |-> !baud16_tick)
      else $error("tick with zero divisor");
  AST_TICK_GAP:
    assert property (baud16_tick && c2 ##1 c2 |-> !baud16_tick ##1 (baud16_tick || !c2))
      else $error("tick spacing wrong");
  AST_TX_LOAD:
    assert property (!blk_q && !wr && tx_load |=> !tx_dma_request)
      else $error("tx request kept after load");
  AST_RX_EMPTY:
    assert property (blk_q && !wr && rx_count == 7'h00 |=> !rx_dma_request)
      else $error("rx request with empty fifo");
  cover property ($rose(sleeping));
  cover property ($fell(sleeping));
  cover property (blk_q && rx_dma_request);
endmodule
bind uart_dma_sleep_baud_gen uart_dma_sleep_asserts #(.CW(CW)) chk (.clk, .rst,
  .addr, .wdata, .wr, .tx_load, .rx_count, .modem_in, .tx_out, .tx_dma_request,
  .rx_dma_request, .baud16_tick, .uart_clk_en, .sleeping);
`default_nettype wire

// File: bench/dma_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// dma controller and fifo fill model
module dma_partner (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // bench control
  input wire logic  en,
  input wire logic  slow,
  input wire logic  rx_add,
  input wire logic  drain,
  // requests
  input wire logic  tx_dma_request,
  input wire logic  rx_dma_request,
  // fifo side
  output logic [6:0] tx_count,
  output logic [6:0] rx_count,
  output logic       tx_fifo_write,
  output logic       tx_load
);
  logic [1:0] ph_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
      tx_count <= 7'h00;
      rx_count <= 7'h00;
      tx_fifo_write <= 1'b0;
      tx_load <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      tx_fifo_write <= 1'b0;
      tx_load <= 1'b0;
      // drain stands for the transmitter taking characters
      if (drain) begin
        if (tx_count != 7'h00) tx_count <= tx_count - 7'h01;
      end else if (en && (!slow || ph_q == 2'h0) && tx_dma_request
                   && tx_count < 7'h40 && !tx_fifo_write) begin
        tx_count <= tx_count + 7'h01;
        tx_fifo_write <= 1'b1;
        tx_load <= 1'b1;
      end
      if (rx_add) rx_count <= rx_count + 7'h01;
      else if (rx_count != 7'h00 && (drain || (en && rx_dma_request)))
        rx_count <= rx_count - 7'h01;
    end
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_dma_sleep_defines.vh"
// ==========
// bench top
module testbench;
  logic       clk, rst, wr, rd, rd_p, tx_fifo_write, tx_load, rx_timeout_irq;
  logic       tx_shift_empty, other_irq, rx, tx_serial, tx_out, en, slow;
  logic       rx_add, drain, tx_dma_request, rx_dma_request, baud16_tick;
  logic       uart_clk_en, sleeping;
  logic [3:0] addr, modem_in;
  logic [7:0] wdata, rdata, dv;
  logic [6:0] tx_count, rx_count, rx_err_count;
  logic [7:0] exp_q[$];
  int         n_mismatch, n_tests, ticks, t0;
  uart_dma_sleep_baud_gen dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .tx_count, .tx_shift_empty, .tx_fifo_write, .tx_load, .rx_count,
    .rx_err_count, .rx_timeout_irq, .other_irq, .rx, .modem_in, .tx_serial,
    .tx_out, .tx_dma_request, .rx_dma_request, .baud16_tick, .uart_clk_en,
    .sleeping);
  dma_partner far (.clk, .rst, .en, .slow, .rx_add, .drain, .tx_dma_request,
    .rx_dma_request, .tx_count, .rx_count, .tx_fifo_write, .tx_load);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input [15:0] seen, input [15:0] want, input string nm);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, want, seen);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wreg(input [3:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rreg(input [3:0] a, input [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task pulse_in(input int which);
    if (which == 0) drain <= 1'b1;
    else rx_add <= 1'b1;
    @(posedge clk);
    drain <= 1'b0;
    rx_add <= 1'b0;
    cyc(3);
    @(negedge clk);
  endtask
  // settle one window, then count ticks over the next
  task tick_chk(input int n, input int want);
    repeat (n) @(negedge clk);
    t0 = ticks;
    repeat (n) @(negedge clk);
    chk(ticks - t0, want, "ticks");
  endtask
  task wake_chk;
    int k;
    k = 0;
    repeat (4) begin
      @(negedge clk);
      if (sleeping === 1'b0) k = 1;
    end
    chk(k, 1, "wake");
  endtask
  always @(posedge clk) begin
    if (baud16_tick === 1'b1) ticks++;
    if (rd_p) chk(rdata, exp_q.pop_front(), "rdata");
    rd_p <= rd;
  end
  initial begin
    #(100 * 12000);
    n_mismatch++;
    final_report;
  end
  initial begin
    void'($urandom(84));
    {wr, rd, rd_p, rx_timeout_irq, other_irq, en, slow, rx_add, drain} = '0;
    {tx_shift_empty, rx, tx_serial, rst} = 4'hF;
    {addr, modem_in, wdata, rx_err_count} = '0;
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    rreg(`A_LCTL, 8'h1D);
    rreg(`A_MCTL, 8'h00);
    rreg(`A_LSTAT, 8'h60);
    rreg(4'hB, 8'h00);
    rreg(`A_STATUS, 8'h04);
    dv = 8'(1 + $urandom % 8);
    wreg(`A_DIV_LO, dv);
    rreg(`A_DIV_LO, dv);
    tick_chk(24 * dv, 24);
    wreg(`A_MCTL, 8'h80);
    tick_chk(96 * dv, 24);
    wreg(`A_MCTL, 8'h00);
    wreg(`A_DIV_LO, 8'h00);
    wreg(`A_DIV_HI, 8'h01);
    tick_chk(512, 2);
    wreg(`A_DIV_HI, 8'h00);
    tick_chk(50, 0);
    wreg(`A_DIV_LO, 8'h02);
    tick_chk(40, 20);
    wreg(`A_LCTL, 8'h5D);
    @(negedge clk);
    chk(tx_out, 1'b0, "break");
    wreg(`A_LCTL, 8'h1D);
    pulse_in(1);
    chk(rx_dma_request, 1'b1, "rxreq");
    en <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(tx_count, 7'h01, "txcnt");
    chk(rx_dma_request, 1'b0, "rxreq");
    en <= 1'b0;
    wreg(`A_TX_TRIG, 8'h08);
    wreg(`A_RX_TRIG, 8'h04);
    wreg(`A_FCTL, 8'h08);
    @(negedge clk);
    chk(tx_dma_request, 1'b0, "txreq");
    wreg(`A_FCTL, 8'h09);
    @(negedge clk);
    chk(tx_dma_request, 1'b1, "txreq");
    slow <= 1'b1;
    en <= 1'b1;
    cyc(400);
    drain <= 1'b1;
    cyc(7);
    drain <= 1'b0;
    cyc(20);
    @(negedge clk);
    chk(tx_count, 7'h39, "txcnt");
    pulse_in(0);
    cyc(60);
    @(negedge clk);
    chk(tx_count, 7'h40, "txcnt");
    en <= 1'b0;
    repeat (3) pulse_in(1);
    chk(rx_dma_request, 1'b0, "rxreq");
    pulse_in(1);
    chk(rx_dma_request, 1'b1, "rxreq");
    rx_err_count <= 7'h01;
    cyc(3);
    @(negedge clk);
    chk(rx_dma_request, 1'b0, "rxreq");
    rx_err_count <= 7'h00;
    en <= 1'b1;
    cyc(12);
    @(negedge clk);
    chk(rx_count, 7'h00, "rxcnt");
    en <= 1'b0;
    rx_timeout_irq <= 1'b1;
    pulse_in(1);
    chk(rx_dma_request, 1'b1, "rxreq");
    rx_timeout_irq <= 1'b0;
    wreg(`A_FCTL, 8'h00);
    drain <= 1'b1;
    cyc(70);
    drain <= 1'b0;
    pulse_in(1);
    wreg(`A_DIV_LO, 8'h01);
    wreg(`A_EFEAT, 8'h10);
    wreg(`A_IEN, 8'h10);
    cyc(700);
    @(negedge clk);
    chk(sleeping, 1'b0, "sleep");
    pulse_in(0);
    cyc(700);
    @(negedge clk);
    chk(sleeping, 1'b1, "sleep");
    chk(uart_clk_en, 1'b0, "clken");
    tick_chk(20, 0);
    modem_in <= modem_in ^ 4'(1 + $urandom % 15);
    wake_chk;
    cyc(20);
    rx <= 1'b0;
    @(posedge clk);
    rx <= 1'b1;
    wake_chk;
    wreg(`A_IEN, 8'h00);
    cyc(700);
    @(negedge clk);
    chk(sleeping, 1'b0, "sleep");
    final_report;
  end
endmodule
`default_nettype wire
